// ### design/scpm_params.svh
// Register offsets, field positions, reset values and timing counts
`ifndef SCPM_PARAMS_SVH
`define SCPM_PARAMS_SVH
// Register indexes on the plain register port
`define SCPM_CLKCTL_OFS 2'h0
`define SCPM_FOC_OFS 2'h1
`define SCPM_WAKE_OFS 2'h2
`define SCPM_STAT_OFS 2'h3
// System clock control fields
`define SCPM_CKS_MSB 7
`define SCPM_CKS_LSB 5
`define SCPM_FIDLE_BIT 1
`define SCPM_SIDLE_BIT 0
// Fast oscillator control fields
`define SCPM_FSTAB_BIT 1
`define SCPM_FEN_BIT 0
// Reset values
`define SCPM_CKS_RST 3'h0
`define SCPM_FEN_RST 1'b1
`define SCPM_WAKE_RST 8'h00
// Select codes
`define SCPM_SEL_FAST 3'h0
`define SCPM_SEL_SUB 3'h7
// Periods in picoseconds, and derived cycle counts
`define SCPM_CORE_PERIOD_PS 5000
`define SCPM_FAST_PERIOD_PS 125000
`define SCPM_SLOW_PERIOD_PS 31250000
`define SCPM_FAST_DIV (`SCPM_FAST_PERIOD_PS / `SCPM_CORE_PERIOD_PS)
`define SCPM_SLOW_DIV (`SCPM_SLOW_PERIOD_PS / `SCPM_CORE_PERIOD_PS)
// Oscillator settle times in core cycles
`define SCPM_FAST_SETTLE 64
`define SCPM_SLOW_SETTLE 64
// Current-clock periods waited before a switch
`define SCPM_SW_WAIT 3'h4
`endif

// ### design/scpm_pkg.sv
// Types for the system clock and power mode controller
package scpm_pkg;
    typedef enum logic [2:0] {SCPM_FAST, SCPM_SLOW, SCPM_SLEEP, SCPM_IDLE0, SCPM_IDLE1, SCPM_IDLE2} scpm_mode_type;
    typedef enum logic {SCPM_RUN, SCPM_HALT} scpm_phase_type;
    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } scpm_bus_type;
    typedef struct packed {
        scpm_phase_type phase;
        scpm_mode_type mode;
        logic [2:0] cks;
        logic [2:0] sel;
        logic fast_idle;
        logic slow_idle;
        logic fen;
        logic [7:0] wake_en;
        logic [7:0] pa_s1;
        logic [7:0] pa_s2;
        logic [7:0] pa_s3;
        logic [4:0] fdiv;
        logic fon;
        logic [7:0] fsettle;
        logic fstable;
        logic [12:0] sdiv;
        logic son;
        logic [7:0] ssettle;
        logic sstable;
        logic [5:0] pre;
        logic [2:0] swcnt;
        logic sys_tick;
        logic fast_tick;
        logic sub_tick;
        logic cpu_run;
        logic pdf_set;
        logic to_clr;
        logic wdt_clr;
        logic [7:0] rdata;
    } scpm_state_type;
endpackage

// ### design/scpm_clock_power.sv
// System clock selection, oscillator control and power-down modes
`timescale 1ns/1ps
`default_nettype none
`include "scpm_params.svh"
// Operation
// - Select codes pick fast, divided, or sub-clock
// - Halt, both idle bits low: SLEEP
// - Halt, slow idle only: IDLE0
// - Halt, both idle bits high: IDLE1
// - Halt, fast idle only: IDLE2
// - Power-down halts CPU, sets flag, clears timeout
// - Power-down clears the watchdog counter
// - SLOW mode fast clock follows enable bit unless a switch away from sub-clock is pending
// - Stable flag clears, then rises when settled
// - Switch ends after four current clocks plus alignment
// - Switch to sub-clock waits slow oscillator stable
// - Unimplemented control bits read as zero
// - Wake on port edge, interrupt, watchdog overflow
module scpm_clock_power #(
    parameter int SLOW_DIV = `SCPM_SLOW_DIV
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Register port
    input wire scpm_pkg::scpm_bus_type bus_in,
    output logic [7:0] reg_rdata,
    // Core and wake-up sources
    input wire logic halt_req,
    input wire logic int_req,
    input wire logic wdt_overflow,
    input wire logic wdt_enabled,
    input wire logic [7:0] porta_pin,
    // Clock enables
    output logic sys_clk_en,
    output logic fast_clk_en,
    output logic sub_clk_en,
    output logic fast_osc_run,
    output logic slow_osc_run,
    // Core status
    output logic cpu_run,
    output logic power_down_flag_set,
    output logic watchdog_timeout_flag_clr,
    output logic watchdog_clr
);
    import scpm_pkg::*;

    scpm_state_type cur_reg;
    scpm_state_type cur_next;
    logic ftick;
    logic stick;
    logic tgt_tick;
    logic tgt_ok;
    logic wake;
    logic fon_want;
    logic son_want;
    logic fen_rise;

    // Tick for a select code; divided ticks align on prescaler wrap
    function automatic logic tick_of(input logic [2:0] code, input logic [5:0] pre, input logic ft,
                                     input logic st);
        logic [5:0] mask;
        mask = 6'((7'h1 << code) - 7'h1);
        if (code == `SCPM_SEL_SUB)
            tick_of = st;
        else
            tick_of = ft && ((pre & mask) == mask);
    endfunction

    // Next-state logic for the whole block
    always_comb
    begin
        cur_next = cur_reg;
        // Pulses default low
        cur_next.pdf_set = 1'b0;
        cur_next.to_clr = 1'b0;
        cur_next.wdt_clr = 1'b0;
        cur_next.rdata = 8'h00;

        // Port pins pass two flops before the edge detector
        cur_next.pa_s1 = porta_pin;
        cur_next.pa_s2 = cur_reg.pa_s1;
        cur_next.pa_s3 = cur_reg.pa_s2;
        wake = int_req || wdt_overflow || |(cur_reg.pa_s3 & ~cur_reg.pa_s2 & cur_reg.wake_en);

        // Register writes
        fen_rise = 1'b0;
        if (bus_in.wr)
        begin
            case (bus_in.addr)
                `SCPM_CLKCTL_OFS:
                begin
                    cur_next.cks = bus_in.wdata[`SCPM_CKS_MSB:`SCPM_CKS_LSB];
                    cur_next.fast_idle = bus_in.wdata[`SCPM_FIDLE_BIT];
                    cur_next.slow_idle = bus_in.wdata[`SCPM_SIDLE_BIT];
                    if (cur_next.cks != cur_reg.cks)
                        cur_next.swcnt = 3'h0; // Restart the wait on a new target
                end
                `SCPM_FOC_OFS:
                begin
                    cur_next.fen = bus_in.wdata[`SCPM_FEN_BIT];
                    fen_rise = bus_in.wdata[`SCPM_FEN_BIT] && !cur_reg.fen;
                end
                `SCPM_WAKE_OFS:
                    cur_next.wake_en = bus_in.wdata;
                default:
                    cur_next.wake_en = cur_reg.wake_en; // Status is read-only
            endcase
        end

        // Register reads, answered one cycle later
        if (bus_in.rd)
        begin
            case (bus_in.addr)
                `SCPM_CLKCTL_OFS:
                    cur_next.rdata = {cur_reg.cks, 3'h0, cur_reg.fast_idle, cur_reg.slow_idle};
                `SCPM_FOC_OFS:
                    cur_next.rdata = {6'h00, cur_reg.fstable, cur_reg.fen};
                `SCPM_WAKE_OFS:
                    cur_next.rdata = cur_reg.wake_en;
                default:
                    cur_next.rdata = {3'h0, cur_reg.sstable, (cur_reg.cks != cur_reg.sel), 3'(cur_reg.mode)};
            endcase
        end

        // Run/halt sequencing
        case (cur_reg.phase)
            SCPM_RUN:
                if (halt_req)
                begin
                    cur_next.phase = SCPM_HALT;
                    cur_next.pdf_set = 1'b1;
                    cur_next.to_clr = 1'b1;
                    cur_next.wdt_clr = 1'b1;
                end
            SCPM_HALT:
                if (wake)
                    cur_next.phase = SCPM_RUN;
            default:
                cur_next.phase = SCPM_RUN;
        endcase

        // Operating mode from phase and idle bits
        if (cur_next.phase == SCPM_RUN)
            cur_next.mode = (cur_reg.sel == `SCPM_SEL_SUB) ? SCPM_SLOW : SCPM_FAST;
        else
        begin
            case ({cur_next.fast_idle, cur_next.slow_idle})
                2'b00: cur_next.mode = SCPM_SLEEP;
                2'b01: cur_next.mode = SCPM_IDLE0;
                2'b11: cur_next.mode = SCPM_IDLE1;
                default: cur_next.mode = SCPM_IDLE2;
            endcase
        end

        // Fast oscillator: runs unless no mode needs it
        if (cur_next.phase == SCPM_HALT)
            fon_want = cur_next.fast_idle;
        else
            fon_want = cur_reg.fen || cur_reg.sel != `SCPM_SEL_SUB || cur_reg.cks != `SCPM_SEL_SUB;
        cur_next.fon = fon_want;
        if (!fon_want || fen_rise || !cur_reg.fon)
        begin
            cur_next.fsettle = 8'h00;
            cur_next.fstable = 1'b0;
        end
        else if (cur_reg.fsettle == 8'(`SCPM_FAST_SETTLE - 1))
            cur_next.fstable = 1'b1;
        else
            cur_next.fsettle = cur_reg.fsettle + 8'h01;

        // Slow oscillator: stops only in SLEEP without the watchdog
        son_want = !(cur_next.mode == SCPM_SLEEP && !wdt_enabled);
        cur_next.son = son_want;
        if (!son_want || !cur_reg.son)
        begin
            cur_next.ssettle = 8'h00;
            cur_next.sstable = 1'b0;
        end
        else if (cur_reg.ssettle == 8'(`SCPM_SLOW_SETTLE - 1))
            cur_next.sstable = 1'b1;
        else
            cur_next.ssettle = cur_reg.ssettle + 8'h01;

        // Oscillator dividers; ticks only once settled
        ftick = cur_reg.fstable && cur_reg.fdiv == 5'(`SCPM_FAST_DIV - 1);
        stick = cur_reg.sstable && cur_reg.sdiv == 13'(SLOW_DIV - 1);
        cur_next.fdiv = (!cur_reg.fon || ftick) ? 5'h00 : cur_reg.fdiv + 5'h01;
        cur_next.sdiv = (!cur_reg.son || stick) ? 13'h0000 : cur_reg.sdiv + 13'h0001;
        if (ftick)
            cur_next.pre = cur_reg.pre + 6'h01;

        // Source switch: count current ticks, then land on a target tick
        tgt_tick = tick_of(cur_reg.cks, cur_reg.pre, ftick, stick);
        tgt_ok = (cur_reg.cks == `SCPM_SEL_SUB) ? cur_reg.sstable : cur_reg.fstable;
        if (cur_reg.cks != cur_reg.sel && cur_next.cks == cur_reg.cks)
        begin
            if (cur_reg.swcnt != `SCPM_SW_WAIT)
            begin
                if (cur_reg.sys_tick)
                    cur_next.swcnt = cur_reg.swcnt + 3'h1;
            end
            else if (tgt_tick && tgt_ok)
            begin
                cur_next.sel = cur_reg.cks;
                cur_next.swcnt = 3'h0;
            end
        end
        // Run mode follows the source in use after this edge, so status agrees with the pending bit
        if (cur_next.phase == SCPM_RUN)
            cur_next.mode = (cur_next.sel == `SCPM_SEL_SUB) ? SCPM_SLOW : SCPM_FAST;

        // Clock enables from the source in use after this edge
        cur_next.sys_tick = (cur_next.phase == SCPM_RUN) && tick_of(cur_next.sel, cur_reg.pre, ftick, stick);
        cur_next.fast_tick = ftick && cur_next.fon;
        cur_next.sub_tick = stick && !(cur_next.phase == SCPM_HALT && !cur_next.slow_idle);
        cur_next.cpu_run = (cur_next.phase == SCPM_RUN);
    end

    // State register
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            cur_reg <= '0;
            cur_reg.phase <= SCPM_RUN;
            cur_reg.mode <= SCPM_FAST;
            cur_reg.cks <= `SCPM_CKS_RST;
            cur_reg.sel <= `SCPM_CKS_RST;
            cur_reg.fen <= `SCPM_FEN_RST;
            cur_reg.wake_en <= `SCPM_WAKE_RST;
            cur_reg.cpu_run <= 1'b1;
        end
        else
            cur_reg <= cur_next;
    end

    // Outputs straight from the state register
    assign reg_rdata = cur_reg.rdata;
    assign sys_clk_en = cur_reg.sys_tick;
    assign fast_clk_en = cur_reg.fast_tick;
    assign sub_clk_en = cur_reg.sub_tick;
    assign fast_osc_run = cur_reg.fon;
    assign slow_osc_run = cur_reg.son;
    assign cpu_run = cur_reg.cpu_run;
    assign power_down_flag_set = cur_reg.pdf_set;
    assign watchdog_timeout_flag_clr = cur_reg.to_clr;
    assign watchdog_clr = cur_reg.wdt_clr;

    default clocking @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    // Power-down entry sequence
    sequence halt_taken;
        cur_reg.phase == SCPM_RUN && halt_req;
    endsequence
    sequence entry_pulses;
        power_down_flag_set && watchdog_timeout_flag_clr && watchdog_clr && !cpu_run;
    endsequence

    a_halt_entry: assert property (halt_taken |=> entry_pulses ##1 !power_down_flag_set)
        else $error("power-down entry pulses wrong");
    a_halt_wdt: assert property (halt_taken |=> watchdog_clr ##1 !watchdog_clr)
        else $error("watchdog clear not one pulse");
    a_sleep_clocks: assert property (cur_reg.mode == SCPM_SLEEP |-> !sub_clk_en && !fast_osc_run && !sys_clk_en)
        else $error("clock running in sleep");
    a_idle0_clocks: assert property (cur_reg.mode == SCPM_IDLE0 |-> !fast_osc_run && slow_osc_run)
        else $error("idle0 oscillator state wrong");
    a_idle1_clocks: assert property (cur_reg.mode == SCPM_IDLE1 |-> fast_osc_run && slow_osc_run && !cpu_run)
        else $error("idle1 oscillator state wrong");
    a_idle2_clocks: assert property (cur_reg.mode == SCPM_IDLE2 |-> fast_osc_run && !sub_clk_en)
        else $error("idle2 clock state wrong");
    a_fast_select: assert property (cpu_run && cur_reg.sel == `SCPM_SEL_FAST |-> sys_clk_en == fast_clk_en)
        else $error("fast select does not follow fast clock");
    a_slow_enable: assert property (cpu_run && cur_reg.sel == `SCPM_SEL_SUB && cur_reg.cks == `SCPM_SEL_SUB
        && !cur_reg.fen && !halt_req |=> !fast_osc_run)
        else $error("fast oscillator runs while disabled in slow mode");
    a_stable_clear: assert property (bus_in.wr && bus_in.addr == `SCPM_FOC_OFS && bus_in.wdata[0] && !cur_reg.fen
        |=> !cur_reg.fstable)
        else $error("stable flag not cleared on enable");
    a_switch_wait: assert property ($changed(cur_reg.sel) |-> $past(cur_reg.swcnt) == `SCPM_SW_WAIT)
        else $error("switch before four current clocks");
    a_sub_stable: assert property ($changed(cur_reg.sel) && cur_reg.sel == `SCPM_SEL_SUB
        |-> $past(cur_reg.sstable))
        else $error("switched to sub-clock before slow oscillator stable");
    a_read_zero: assert property (bus_in.rd && bus_in.addr == `SCPM_CLKCTL_OFS |=> reg_rdata[4:2] == 3'h0)
        else $error("unimplemented bits not zero");
    a_wake_int: assert property (cur_reg.phase == SCPM_HALT && int_req |=> cpu_run)
        else $error("no wake on interrupt");
endmodule
`default_nettype wire

// ### sim/scpm_clock_power_tb.sv
// Self-checking testbench for the system clock and power mode controller
`timescale 1ns/1ps
`default_nettype none
`include "scpm_params.svh"
module scpm_clock_power_tb;
    import scpm_pkg::*;
    // Short sub-clock division keeps the slow-mode checks brief
    localparam int SLOW_DIV = 20;
    localparam int FAST_DIV = `SCPM_FAST_DIV;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    scpm_bus_type bus_in = '0;
    logic [7:0] reg_rdata;
    logic halt_req = 1'b0;
    logic int_req = 1'b0;
    logic wdt_overflow = 1'b0;
    logic wdt_enabled = 1'b0;
    logic [7:0] porta_pin = 8'hff;
    logic sys_clk_en;
    logic fast_clk_en;
    logic sub_clk_en;
    logic fast_osc_run;
    logic slow_osc_run;
    logic cpu_run;
    logic power_down_flag_set;
    logic watchdog_timeout_flag_clr;
    logic watchdog_clr;
    int miscompares = 0;
    int num_checks = 0;
    int cyc = 0;
    logic [2:0] cur_sel = 3'h0;

    scpm_clock_power #(.SLOW_DIV(SLOW_DIV)) u_scpm_clock_power (
        .core_clk(core_clk), .sys_rst(sys_rst), .bus_in(bus_in), .reg_rdata(reg_rdata),
        .halt_req(halt_req), .int_req(int_req), .wdt_overflow(wdt_overflow), .wdt_enabled(wdt_enabled),
        .porta_pin(porta_pin), .sys_clk_en(sys_clk_en), .fast_clk_en(fast_clk_en), .sub_clk_en(sub_clk_en),
        .fast_osc_run(fast_osc_run), .slow_osc_run(slow_osc_run), .cpu_run(cpu_run),
        .power_down_flag_set(power_down_flag_set), .watchdog_timeout_flag_clr(watchdog_timeout_flag_clr),
        .watchdog_clr(watchdog_clr));

    // Clock at 200 MHz
    always #2.5 core_clk = ~core_clk;

    // Cycle count doubles as the hang guard
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 60000)
        begin
            miscompares++;
            results();
        end
    end

    task results;
        $display("checks=%0d miscompares=%0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One-cycle write strobe
    task wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge core_clk);
        bus_in.addr <= a;
        bus_in.wdata <= d;
        bus_in.wr <= 1'b1;
        @(posedge core_clk);
        bus_in.wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge core_clk);
        bus_in.addr <= a;
        bus_in.rd <= 1'b1;
        @(posedge core_clk);
        bus_in.rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    function automatic int per(input logic [2:0] c);
        return (c == 3'h7) ? SLOW_DIV : (FAST_DIV << c);
    endfunction

    // Bounded wait for the next system tick, sampled on the quiet edge
    task wait_tick;
        int n;
        n = 0;
        @(negedge core_clk);
        while (sys_clk_en !== 1'b1 && n < 4000)
        begin
            @(negedge core_clk);
            n++;
        end
    endtask

    task spacing(output int dt);
        int t0;
        wait_tick();
        t0 = cyc;
        wait_tick();
        dt = cyc - t0;
    endtask

    task reg_test;
        logic [7:0] d;
        int dt;
        rd(`SCPM_CLKCTL_OFS, d);
        chk(32'(d), 32'h0);
        rd(`SCPM_FOC_OFS, d);
        chk(32'(d), 32'h1);
        wr(`SCPM_CLKCTL_OFS, 8'h1c);
        rd(`SCPM_CLKCTL_OFS, d);
        chk(32'(d), 32'h0);
        wr(`SCPM_WAKE_OFS, 8'h01);
        rd(`SCPM_WAKE_OFS, d);
        chk(32'(d), 32'h1);
        // Status is read-only; a write there must not disturb the mode
        wr(`SCPM_STAT_OFS, 8'hff);
        rd(`SCPM_STAT_OFS, d);
        chk(32'(d & 8'h0f), 32'h0);
        repeat (`SCPM_FAST_SETTLE + 16) @(negedge core_clk);
        rd(`SCPM_FOC_OFS, d);
        chk(32'(d), 32'h3);
        spacing(dt);
        chk(32'(dt), 32'(per(3'h0)));
    endtask

    // Poll the pending bit so the switch delay is measured, then the new tick rate
    task switch_to(input logic [2:0] c);
        logic [7:0] st;
        int t0;
        int n;
        int dt;
        wr(`SCPM_CLKCTL_OFS, {c, 5'h00});
        t0 = cyc;
        n = 0;
        st = 8'h08;
        while (st[3] !== 1'b0 && n < 6000)
        begin
            rd(`SCPM_STAT_OFS, st);
            n++;
        end
        dt = cyc - t0;
        chk(32'(dt >= 3 * per(cur_sel)), 32'h1);
        chk(32'(dt <= 6 * per(cur_sel) + 2 * per(c) + 8), 32'h1);
        chk(32'(st[2:0]), (c == 3'h7) ? 32'h1 : 32'h0);
        if (c == 3'h7)
            chk(32'(st[4]), 32'h1);
        spacing(dt);
        chk(32'(dt), 32'(per(c)));
        cur_sel = c;
    endtask

    // In SLOW mode the fast oscillator follows its enable bit
    task fen_test;
        logic [7:0] d;
        @(negedge core_clk);
        chk(32'(fast_osc_run), 32'h1);
        wr(`SCPM_FOC_OFS, 8'h00);
        repeat (4) @(negedge core_clk);
        chk(32'(fast_osc_run), 32'h0);
        rd(`SCPM_FOC_OFS, d);
        chk(32'(d), 32'h0);
        wr(`SCPM_FOC_OFS, 8'hff);
        rd(`SCPM_FOC_OFS, d);
        chk(32'(d), 32'h1);
        repeat (`SCPM_FAST_SETTLE + 8) @(negedge core_clk);
        rd(`SCPM_FOC_OFS, d);
        chk(32'(d), 32'h3);
        chk(32'(fast_osc_run), 32'h1);
    endtask

    // Enter one power-down mode, check clocks and flags, then wake by one source
    task halt_in(input logic fh, input logic fs, input logic wen, input int src, input logic [2:0] mcode);
        logic [7:0] st;
        int n;
        int subs;
        int syss;
        int fasts;
        wr(`SCPM_CLKCTL_OFS, {6'h00, fh, fs});
        wdt_enabled <= wen;
        @(posedge core_clk);
        halt_req <= 1'b1;
        @(posedge core_clk);
        halt_req <= 1'b0;
        #1;
        chk(32'({power_down_flag_set, watchdog_timeout_flag_clr, watchdog_clr, cpu_run}), 32'he);
        // A second request while halted is ignored
        @(posedge core_clk);
        halt_req <= 1'b1;
        @(posedge core_clk);
        halt_req <= 1'b0;
        #1;
        chk(32'({power_down_flag_set, watchdog_timeout_flag_clr, watchdog_clr, cpu_run}), 32'h0);
        subs = 0;
        syss = 0;
        fasts = 0;
        // Long enough for a freshly restarted fast oscillator to settle and tick
        repeat (8 * SLOW_DIV) @(negedge core_clk)
        begin
            if (sub_clk_en === 1'b1)
                subs++;
            if (fast_clk_en === 1'b1)
                fasts++;
            if (sys_clk_en === 1'b1)
                syss++;
        end
        chk(32'(subs > 0), 32'(fs));
        chk(32'(syss), 32'h0);
        chk(32'(fasts > 0), 32'(fh));
        chk(32'({fast_osc_run, slow_osc_run}), 32'({fh, fh | fs | wen}));
        rd(`SCPM_STAT_OFS, st);
        chk(32'(st[2:0]), 32'(mcode));
        if (src == 2)
        begin
            // A falling edge on a pin that is not enabled must not wake
            @(posedge core_clk);
            porta_pin <= 8'hfd;
            repeat (8) @(negedge core_clk);
            chk(32'(cpu_run), 32'h0);
            @(posedge core_clk);
            porta_pin <= 8'hfc;
        end
        else
        begin
            @(posedge core_clk);
            if (src == 0)
                int_req <= 1'b1;
            else
                wdt_overflow <= 1'b1;
            @(posedge core_clk);
            int_req <= 1'b0;
            wdt_overflow <= 1'b0;
        end
        n = 0;
        while (cpu_run !== 1'b1 && n < 10)
        begin
            @(negedge core_clk);
            n++;
        end
        chk(32'(cpu_run), 32'h1);
        @(posedge core_clk);
        porta_pin <= 8'hff;
        repeat (6) @(negedge core_clk);
    endtask

    // Main sequence
    initial
    begin
        repeat (6) @(posedge core_clk);
        sys_rst <= 1'b0;
        reg_test();
        for (int c = 1; c < 8; c++)
            switch_to(3'(c));
        fen_test();
        switch_to(3'h0);
        halt_in(1'b0, 1'b1, 1'b0, 0, 3'h3);
        halt_in(1'b1, 1'b1, 1'b0, 1, 3'h4);
        halt_in(1'b1, 1'b0, 1'b0, 2, 3'h5);
        halt_in(1'b0, 1'b0, 1'b1, 0, 3'h2);
        halt_in(1'b0, 1'b0, 1'b0, 1, 3'h2);
        results();
    end
endmodule
`default_nettype wire
